// >>> design/slch_pkg.sv
/*
 * Shared constants for the servo link command handshake block: response codes, instruction
 * code ranges, setpoint source selections, input function positions and the local register map.
 * Assumes every user imports the whole package.
 */
package slch_pkg;

  // Response codes placed in the response word.
  localparam logic [15:0] RESP_OK = 16'h0000;
  localparam logic [15:0] RESP_CODE_ERR = 16'h0001;
  localparam logic [15:0] RESP_SEL_ERR = 16'h0002;
  localparam logic [15:0] RESP_RANGE_ERR = 16'h0003;

  // Instruction code ranges.
  localparam logic [15:0] RD_CODE_MAX = 16'h0a1f;
  localparam logic [15:0] WR_CODE_MIN = 16'h8000;
  localparam logic [15:0] WR_CODE_MAX = 16'h911f;

  // Table numbers from this value upward are rejected.
  localparam logic [15:0] TABLE_LIMIT = 16'h00ff;

  // Setpoint source selections.
  localparam logic [1:0] SRC_TABLE = 2'h0;
  localparam logic [1:0] SRC_POS_TABLE = 2'h1;
  localparam logic [1:0] SRC_POS_SPEED = 2'h2;
  localparam logic [7:0] ACCEL_TABLE_DIRECT = 8'h01;

  // Input function positions and the assignment reset value.
  localparam int IN_FWD_STROKE = 0;
  localparam int IN_REV_STROKE = 1;
  localparam int IN_PROX_DOG = 2;
  localparam logic [7:0] ASSIGN_RESET = 8'h07;

  // Local register map, byte addresses of 32-bit words.
  localparam logic [7:0] REG_SRC = 8'h00;
  localparam logic [7:0] REG_ASSIGN = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_REF_MASK = 8'h0c;
  localparam logic [7:0] REG_WR_LIMIT = 8'h10;
  localparam logic [7:0] REG_SPD_MAX = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // Register reset values.
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic CFG_RESET = 1'b0;
  localparam logic [15:0] REF_MASK_RESET = 16'h07ff;
  localparam logic [15:0] WR_LIMIT_RESET = 16'hffff;
  localparam logic [15:0] SPD_MAX_RESET = 16'hffff;

  typedef enum logic [1:0] {
    INS_IDLE = 2'b00,
    INS_BUSY = 2'b01,
    INS_DONE = 2'b11
  } slch_ins_e;

endpackage : slch_pkg

// >>> design/slch_mem_if.sv
/*
 * Port bundle between the instruction engine and the item store.
 * Assumes one writer of address and data and a read result registered in the store.
 */
`timescale 1ns/1ps
interface slch_mem_if #(
  parameter int AW = 12
);
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic we;
  logic [15:0] rdata;
  modport host (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface : slch_mem_if

// >>> design/slch_item_mem.sv
/*
 * Parameter and point table item store, one 16-bit word per item.
 * Assumes address and write enable valid at the clock edge; read data appear one cycle later.
 */
`timescale 1ns/1ps
module slch_item_mem #(
  parameter int AW = 12
) (
  // Clock
  input wire logic clk,
  // Access port
  slch_mem_if.mem bus
);

  logic [15:0] mem_array [0:(1<<AW)-1];

  // Contents are volatile and undefined until written, as with any RAM.
  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem_array[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    bus.rdata <= mem_array[bus.addr];
  end

endmodule : slch_item_mem

// >>> design/slch_input_route.sv
/*
 * Per-function input router choosing the local connector or the link bit.
 * Assumes all inputs synchronous to clk.
 */
`timescale 1ns/1ps
module slch_input_route #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Selection and sources
  input wire logic [N-1:0] assign_mask,
  input wire logic [N-1:0] link_bits,
  input wire logic [N-1:0] aux_bits,
  // Routed functions
  output logic [N-1:0] routed
);

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_bit
      // A set mask bit makes the link bit of that function irrelevant.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          routed[gi] <= 1'b0;
        end else begin
          routed[gi] <= assign_mask[gi] ? aux_bits[gi] : link_bits[gi]; // RULE4
        end
      end
    end
  endgenerate

endmodule : slch_input_route

// >>> design/slch_top.sv
/*
 * Remote station command handshake: monitor readout, instruction read and write,
 * input assignment and register-based setpoints, plus a small local register port.
 * Assumes link words and bits are synchronous to clk and refreshed by the master station.
 */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Out-of-range codes or numbers give an error response, otherwise response 0000.
// RULE2: Unsupported monitor code or table number 255 or above gives response 1.
// RULE3: Unreferable parameter gives response 2; write beyond limit gives response 3.
// RULE4: Assignment bit 1 takes a function from the connector, 0 from the link.
// RULE5: Stroke-end and proximity-dog inputs come from the connector after reset.
// RULE6: Monitor request rise loads both selected values and raises monitor active.
// RULE7: Master reads 32-bit one-station data with low and high codes together.
// RULE8: Monitor words refresh while requested and freeze once active falls.
// RULE9: An invalid code in either monitor selector reports error 1.
// RULE10: Two-station mode splits each selected 32-bit value over two result words.
// RULE11: An unused upper monitor word holds sign extension 0000 or FFFF.
// RULE12: Read codes 0000h-0A1Fh load the read word and raise done together.
// RULE13: The read word holds until a new read instruction is requested.
// RULE14: Master reads the read word only while done, then drops its request.
// RULE15: Write codes 8000h-911Fh store the write word, then raise done.
// RULE16: Reading an unusable parameter or table returns its error code.
// RULE17: Master holds a write request until done goes high.
// RULE18: Setpoints are taken only with setpoint select high in two-station mode.
// RULE19: Source 0 stores the table number on position request, then position done.
// RULE20: Source 1 stores 32-bit position and speed table, then both done bits.
// RULE21: Source 2 takes speed directly and uses table 1 acceleration constants.
// RULE22: Master starts motion only after every requested completion bit is high.
// RULE23: Completion bits clear once their request bit is dropped.
module slch_top
  import slch_pkg::*;
#(
  parameter int NUM_MON = 16,
  parameter int NUM_INPUTS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link words from the master
  input wire logic [15:0] monitor_select_a,
  input wire logic [15:0] monitor_select_b,
  input wire logic [15:0] instr_code_word,
  input wire logic [15:0] write_value_word,
  input wire logic [15:0] pos_low_or_table_word,
  input wire logic [15:0] pos_high_word,
  input wire logic [15:0] speed_or_table_word,
  // Link request bits from the master
  input wire logic monitor_request,
  input wire logic instr_request,
  input wire logic register_setpoint_select,
  input wire logic position_request,
  input wire logic speed_request,
  input wire logic [NUM_INPUTS-1:0] link_input_bits,
  // Link words to the master
  output logic [15:0] monitor_result_a_low,
  output logic [15:0] monitor_result_a_high,
  output logic [15:0] response_code_word,
  output logic [15:0] read_value_word,
  output logic [15:0] monitor_result_b_low,
  output logic [15:0] monitor_result_b_high,
  // Completion bits to the master
  output logic monitor_active,
  output logic instr_done,
  output logic position_done,
  output logic speed_done,
  // Local connector and routed input functions
  input wire logic [NUM_INPUTS-1:0] aux_input_connector,
  output logic [NUM_INPUTS-1:0] input_function_out,
  // Monitored quantities, 32 bits per code, and their narrow flags
  input wire logic [NUM_MON*32-1:0] mon_value_bus,
  input wire logic [NUM_MON-1:0] mon_narrow,
  // Stored setpoints
  output logic [15:0] setpoint_pos_table,
  output logic [31:0] setpoint_position,
  output logic [15:0] setpoint_speed_table,
  output logic [15:0] setpoint_speed_value,
  output logic [7:0] setpoint_accel_table,
  // Local register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam int MIDX_W = $clog2(NUM_MON);

  generate
    if (NUM_MON < 2 || NUM_MON > 256 || (1 << MIDX_W) != NUM_MON) begin : g_bad_mon
      $error("NUM_MON must be a power of two from 2 to 256");
    end
    if (NUM_INPUTS < 3 || NUM_INPUTS > 32) begin : g_bad_in
      $error("NUM_INPUTS must be from 3 to 32");
    end
  endgenerate

  // Local registers.
  logic [1:0] src_reg;
  logic [NUM_INPUTS-1:0] assign_reg;
  logic two_station_reg;
  logic [15:0] ref_mask_reg;
  logic [15:0] wr_limit_reg;
  logic [15:0] spd_max_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_reg <= SRC_RESET;
      assign_reg <= NUM_INPUTS'(ASSIGN_RESET); // RULE5
      two_station_reg <= CFG_RESET;
      ref_mask_reg <= REF_MASK_RESET;
      wr_limit_reg <= WR_LIMIT_RESET;
      spd_max_reg <= SPD_MAX_RESET;
    end else if (reg_wr) begin
      if (reg_addr == REG_SRC) begin
        src_reg <= reg_wdata[1:0];
      end else if (reg_addr == REG_ASSIGN) begin
        assign_reg <= reg_wdata[NUM_INPUTS-1:0];
      end else if (reg_addr == REG_CFG) begin
        two_station_reg <= reg_wdata[0];
      end else if (reg_addr == REG_REF_MASK) begin
        ref_mask_reg <= reg_wdata[15:0];
      end else if (reg_addr == REG_WR_LIMIT) begin
        wr_limit_reg <= reg_wdata[15:0];
      end else if (reg_addr == REG_SPD_MAX) begin
        spd_max_reg <= reg_wdata[15:0];
      end
    end
  end

  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_addr == REG_SRC) begin
      rdata_next[1:0] = src_reg;
    end else if (reg_addr == REG_ASSIGN) begin
      rdata_next[NUM_INPUTS-1:0] = assign_reg;
    end else if (reg_addr == REG_CFG) begin
      rdata_next[0] = two_station_reg;
    end else if (reg_addr == REG_REF_MASK) begin
      rdata_next[15:0] = ref_mask_reg;
    end else if (reg_addr == REG_WR_LIMIT) begin
      rdata_next[15:0] = wr_limit_reg;
    end else if (reg_addr == REG_SPD_MAX) begin
      rdata_next[15:0] = spd_max_reg;
    end else if (reg_addr == REG_STATUS) begin
      rdata_next = {response_code_word, 12'h000, monitor_active, instr_done,
                    position_done, speed_done};
    end
  end

  // Read data stand only in the cycle after the strobe; zero otherwise.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  slch_input_route #(
    .N(NUM_INPUTS)
  ) u_route (
    .clk(clk),
    .sys_rst(sys_rst),
    .assign_mask(assign_reg),
    .link_bits(link_input_bits),
    .aux_bits(aux_input_connector),
    .routed(input_function_out)
  );

  // Monitor selection.
  logic a_ok;
  logic b_ok;
  logic [MIDX_W-1:0] a_idx;
  logic [MIDX_W-1:0] b_idx;
  logic [31:0] val_a;
  logic [31:0] val_b;
  logic [15:0] upper_a;
  logic [15:0] upper_b;
  logic mon_err;
  logic mon_err_reg;
  logic mon_req_q;

  assign a_ok = monitor_select_a < 16'(NUM_MON); // RULE9
  assign b_ok = monitor_select_b < 16'(NUM_MON); // RULE9
  assign a_idx = monitor_select_a[MIDX_W-1:0];
  assign b_idx = monitor_select_b[MIDX_W-1:0];
  assign val_a = a_ok ? mon_value_bus[a_idx*32 +: 32] : 32'h0000_0000;
  assign val_b = b_ok ? mon_value_bus[b_idx*32 +: 32] : 32'h0000_0000;
  assign upper_a = (a_ok && mon_narrow[a_idx]) ? {16{val_a[15]}} : val_a[31:16]; // RULE11
  assign upper_b = (b_ok && mon_narrow[b_idx]) ? {16{val_b[15]}} : val_b[31:16]; // RULE11
  assign mon_err = !(a_ok && b_ok);

  // Refresh every cycle while requested; when the request drops the words simply stop
  // being written, which is the freeze.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      monitor_active <= 1'b0;
      mon_req_q <= 1'b0;
      mon_err_reg <= 1'b0;
      monitor_result_a_low <= 16'h0000;
      monitor_result_a_high <= 16'h0000;
      monitor_result_b_low <= 16'h0000;
      monitor_result_b_high <= 16'h0000;
    end else begin
      monitor_active <= monitor_request; // RULE6
      mon_req_q <= monitor_request;
      mon_err_reg <= mon_err;
      if (monitor_request) begin // RULE8
        monitor_result_a_low <= val_a[15:0]; // RULE6
        if (two_station_reg) begin // RULE10
          monitor_result_a_high <= upper_a;
          monitor_result_b_low <= val_b[15:0];
          monitor_result_b_high <= upper_b;
        end else begin
          monitor_result_a_high <= val_b[15:0];
        end
      end
    end
  end

  // The monitor reports its status only on a fresh request or a change of validity, so a
  // continuous refresh does not overwrite instruction or setpoint answers.
  logic mon_report;
  assign mon_report = monitor_request && (!mon_req_q || mon_err != mon_err_reg);

  // Instruction engine.
  slch_mem_if #(.AW(12)) mem_bus ();

  slch_item_mem #(
    .AW(12)
  ) u_mem (
    .clk(clk),
    .bus(mem_bus)
  );

  slch_ins_e ins_state_reg;
  logic ins_req_q;
  logic ins_rise;
  logic is_rd;
  logic is_wr;
  logic [15:0] ins_resp;
  logic [15:0] ins_resp_reg;
  logic ins_rd_reg;

  assign ins_rise = instr_request && !ins_req_q;
  assign is_rd = instr_code_word <= RD_CODE_MAX; // RULE12
  assign is_wr = instr_code_word >= WR_CODE_MIN && instr_code_word <= WR_CODE_MAX; // RULE15

  always_comb begin
    ins_resp = RESP_OK;
    if (!(is_rd || is_wr)) begin
      ins_resp = RESP_CODE_ERR; // RULE1
    end else if ({8'h00, instr_code_word[7:0]} >= TABLE_LIMIT) begin
      ins_resp = RESP_CODE_ERR; // RULE2
    end else if (is_rd && !ref_mask_reg[instr_code_word[11:8]]) begin
      ins_resp = RESP_SEL_ERR; // RULE16
    end else if (is_wr && write_value_word > wr_limit_reg) begin
      ins_resp = RESP_RANGE_ERR; // RULE3
    end
  end

  assign mem_bus.addr = instr_code_word[11:0];
  assign mem_bus.wdata = write_value_word;
  assign mem_bus.we = ins_rise && ins_state_reg == INS_IDLE && is_wr && ins_resp == RESP_OK;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ins_state_reg <= INS_IDLE;
      ins_req_q <= 1'b0;
      ins_resp_reg <= RESP_OK;
      ins_rd_reg <= 1'b0;
      instr_done <= 1'b0;
      read_value_word <= 16'h0000;
    end else begin
      ins_req_q <= instr_request;
      case (ins_state_reg)
        INS_IDLE: begin
          if (ins_rise) begin
            ins_resp_reg <= ins_resp;
            ins_rd_reg <= is_rd && ins_resp == RESP_OK;
            ins_state_reg <= INS_BUSY;
          end
        end
        INS_BUSY: begin
          if (ins_rd_reg) begin
            read_value_word <= mem_bus.rdata; // RULE12 RULE13
          end
          instr_done <= 1'b1; // RULE15
          ins_state_reg <= INS_DONE;
        end
        INS_DONE: begin
          if (!instr_request) begin
            instr_done <= 1'b0; // RULE23
            ins_state_reg <= INS_IDLE;
          end
        end
        default: begin
          ins_state_reg <= INS_IDLE;
        end
      endcase
    end
  end

  // Setpoint engine.
  logic sp_en;
  logic pos_req_q;
  logic spd_req_q;
  logic sp_pair;
  logic sp_trig;
  logic [15:0] sp_resp;

  assign sp_en = register_setpoint_select && two_station_reg; // RULE18
  assign sp_pair = (position_request && !pos_req_q) || (speed_request && !spd_req_q);
  assign sp_trig = sp_en && ((src_reg == SRC_TABLE) ? (position_request && !pos_req_q)
                                                    : (sp_pair && position_request && speed_request));

  always_comb begin
    sp_resp = RESP_OK;
    if (src_reg == SRC_TABLE) begin
      if (pos_low_or_table_word >= TABLE_LIMIT) begin
        sp_resp = RESP_CODE_ERR; // RULE1
      end
    end else if (src_reg == SRC_POS_TABLE) begin
      if (speed_or_table_word >= TABLE_LIMIT) begin
        sp_resp = RESP_CODE_ERR; // RULE1
      end
    end else if (src_reg == SRC_POS_SPEED) begin
      if (speed_or_table_word > spd_max_reg) begin
        sp_resp = RESP_RANGE_ERR; // RULE1
      end
    end else begin
      sp_resp = RESP_CODE_ERR;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_req_q <= 1'b0;
      spd_req_q <= 1'b0;
      position_done <= 1'b0;
      speed_done <= 1'b0;
      setpoint_pos_table <= 16'h0000;
      setpoint_position <= 32'h0000_0000;
      setpoint_speed_table <= 16'h0000;
      setpoint_speed_value <= 16'h0000;
      setpoint_accel_table <= 8'h00;
    end else begin
      pos_req_q <= position_request;
      spd_req_q <= speed_request;
      if (!position_request) begin
        position_done <= 1'b0; // RULE23
      end
      if (!speed_request) begin
        speed_done <= 1'b0; // RULE23
      end
      if (sp_trig && sp_resp == RESP_OK) begin
        if (src_reg == SRC_TABLE) begin
          setpoint_pos_table <= pos_low_or_table_word; // RULE19
          position_done <= 1'b1;
        end else begin
          setpoint_position <= {pos_high_word, pos_low_or_table_word}; // RULE20
          position_done <= 1'b1;
          speed_done <= 1'b1;
          if (src_reg == SRC_POS_TABLE) begin
            setpoint_speed_table <= speed_or_table_word; // RULE20
          end else begin
            setpoint_speed_value <= speed_or_table_word; // RULE21
            setpoint_accel_table <= ACCEL_TABLE_DIRECT; // RULE21
          end
        end
      end
    end
  end

  // Response word: an instruction answer outranks a setpoint answer, which outranks
  // a monitor status report in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      response_code_word <= RESP_OK;
    end else if (ins_state_reg == INS_BUSY) begin
      response_code_word <= ins_resp_reg; // RULE1 RULE16
    end else if (sp_trig) begin
      response_code_word <= sp_resp; // RULE1
    end else if (mon_report) begin
      response_code_word <= mon_err ? RESP_CODE_ERR : RESP_OK; // RULE2 RULE9
    end
  end

  AST_MON_RISE: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    $rose(monitor_request) |=> monitor_active && monitor_result_a_low == $past(val_a[15:0]))
    else $error("monitor words not loaded with active on request rise");

  AST_MON_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    !monitor_active && !monitor_request |=> $stable(monitor_result_a_low)
      && $stable(monitor_result_a_high) && $stable(monitor_result_b_high))
    else $error("monitor words changed while monitoring is off");

  AST_MON_ERR: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    $rose(monitor_request) && mon_err && ins_state_reg != INS_BUSY && !sp_trig
      |=> response_code_word == RESP_CODE_ERR)
    else $error("invalid monitor code did not report error 1");

  AST_SIGN_EXT: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    monitor_request && two_station_reg && a_ok && mon_narrow[a_idx]
      |=> monitor_result_a_high == {16{monitor_result_a_low[15]}})
    else $error("upper monitor word is not sign extension");

  AST_READ_DONE: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    $rose(instr_request) && ins_state_reg == INS_IDLE |-> !instr_done ##2 instr_done)
    else $error("instruction done not raised two cycles after request");

  AST_READ_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    ins_state_reg != INS_BUSY |=> $stable(read_value_word))
    else $error("read word changed without a new read instruction");

  AST_WR_RANGE: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    $rose(instr_request) && ins_state_reg == INS_IDLE && is_wr
      && instr_code_word[7:0] != 8'hff && write_value_word > wr_limit_reg
      |-> !mem_bus.we ##2 response_code_word == RESP_RANGE_ERR)
    else $error("write above limit was not refused with error 3");

  AST_DONE_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // RULE23
    (instr_done && !instr_request |=> !instr_done)
      and (position_done && !position_request |=> !position_done))
    else $error("completion bit stayed high after its request dropped");

  AST_SP_GATE: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
    $rose(position_done) |-> $past(register_setpoint_select) && $past(two_station_reg))
    else $error("setpoint accepted without select in two-station mode");

  AST_ASSIGN_INIT: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    $past(sys_rst) |-> assign_reg[IN_FWD_STROKE] && assign_reg[IN_REV_STROKE]
      && assign_reg[IN_PROX_DOG])
    else $error("stroke-end and dog inputs not on the connector after reset");

endmodule : slch_top

// >>> tb/slch_master.sv
/* Master station model driving the link words and request bits.
   Assumes each task is entered just after a rising clk edge. */
`timescale 1ns/1ps
module slch_master (
  // Clock and station answers
  input wire logic clk,
  input wire logic instr_done,
  input wire logic position_done,
  input wire logic speed_done,
  input wire logic [15:0] read_value_word,
  // Link words and request bits
  output logic [15:0] monitor_select_a,
  output logic [15:0] monitor_select_b,
  output logic [15:0] instr_code_word,
  output logic [15:0] write_value_word,
  output logic [15:0] pos_low_or_table_word,
  output logic [15:0] pos_high_word,
  output logic [15:0] speed_or_table_word,
  output logic monitor_request,
  output logic instr_request,
  output logic register_setpoint_select,
  output logic position_request,
  output logic speed_request
);
  initial {monitor_select_a, monitor_select_b, instr_code_word, write_value_word,
    pos_low_or_table_word, pos_high_word, speed_or_table_word, monitor_request,
    instr_request, register_setpoint_select, position_request, speed_request} = '0;

  // Both selectors change together so a 32-bit pair is always read as one.
  task automatic mon(input logic [15:0] a, b, input logic on);
    monitor_select_a <= a;
    monitor_select_b <= b;
    monitor_request <= on;
    repeat (3) @(posedge clk);
  endtask : mon

  task automatic instr(input logic [15:0] code, data, output logic [15:0] rd, output logic dn);
    instr_code_word <= code;
    write_value_word <= data;
    instr_request <= 1'b1;
    repeat (8) if (!instr_done) @(posedge clk);
    dn = instr_done;
    rd = read_value_word;
    instr_request <= 1'b0;
    repeat (8) if (instr_done) @(posedge clk);
    @(posedge clk);
  endtask : instr

  task automatic setp(input logic s, both, input logic [15:0] lo, hi, sp, output logic pd, sd);
    register_setpoint_select <= s;
    pos_low_or_table_word <= lo;
    pos_high_word <= hi;
    speed_or_table_word <= sp;
    position_request <= 1'b1;
    speed_request <= both;
    repeat (3) @(posedge clk);
    // A start would only be issued here, once the done bits have been seen.
    pd = position_done;
    sd = speed_done;
    position_request <= 1'b0;
    speed_request <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : setp
endmodule : slch_master

// >>> tb/servo_link_command_handshake_bench.sv
/* Self-checking bench for slch_top driven through the master station model.
   Assumes the package, the design and slch_master are compiled first. */
`timescale 1ns/1ps
module servo_link_command_handshake_bench import slch_pkg::*; ;
  logic clk, sys_rst, reg_wr, reg_rd, monitor_active, instr_done, position_done, speed_done;
  logic monitor_request, instr_request, register_setpoint_select, position_request;
  logic speed_request, dn, pd, sd;
  logic [15:0] monitor_select_a, monitor_select_b, instr_code_word, write_value_word;
  logic [15:0] pos_low_or_table_word, pos_high_word, speed_or_table_word, response_code_word;
  logic [15:0] monitor_result_a_low, monitor_result_a_high, monitor_result_b_low, rd, d;
  logic [15:0] monitor_result_b_high, read_value_word, setpoint_pos_table, setpoint_speed_table;
  logic [15:0] setpoint_speed_value;
  logic [31:0] setpoint_position, reg_wdata, reg_rdata, seed, v, mv[4];
  logic [7:0] setpoint_accel_table, reg_addr, link_input_bits, aux_input_connector, am;
  logic [7:0] input_function_out;
  logic [127:0] mon_value_bus;
  logic [3:0] mon_narrow;
  logic [15:0] codes[5] = '{16'h0b00, 16'h01ff, 16'h81ff, 16'h0123, 16'h8123};
  logic [15:0] resp[5] = '{RESP_CODE_ERR, RESP_CODE_ERR, RESP_CODE_ERR, RESP_SEL_ERR,
    RESP_RANGE_ERR};
  int failures, n_compared;

  slch_top #(.NUM_MON(4), .NUM_INPUTS(8)) dut (.*);
  slch_master m (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe; take them at the next edge.
  task automatic rdr(input logic [7:0] a, output logic [31:0] dat);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    dat = reg_rdata;
  endtask : rdr

  task automatic put();
    mon_value_bus <= {mv[3], mv[2], mv[1], mv[0]};
    repeat (2) @(posedge clk);
  endtask : put

  task automatic results();
    $display("Comparisons %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    #400000;
    failures++;
    results();
  end

  initial begin
    {seed, sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {32'd56, 1'b1, 42'h0};
    {link_input_bits, aux_input_connector, mon_narrow, mon_value_bus} = {16'h5aa5, 4'h4, 128'h0};
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    am = ASSIGN_RESET;
    repeat (2) @(posedge clk);
    chk(input_function_out, (aux_input_connector & am) | (link_input_bits & ~am));
    am = 8'hf0;
    v = rnd();
    link_input_bits <= v[7:0];
    wr(REG_ASSIGN, {24'h0, am});
    repeat (3) @(posedge clk);
    chk(input_function_out, (aux_input_connector & am) | (link_input_bits & ~am));
    rdr(REG_REF_MASK, v);
    chk(v, {16'h0, REF_MASK_RESET});
    rdr(8'h40, v);
    chk(v, 32'h0);
    foreach (mv[i]) mv[i] = rnd();
    mv[2][15] = 1'b1;
    put();
    m.mon(16'h1, 16'h3, 1'b1);
    chk({monitor_active, monitor_result_a_low}, {1'b1, mv[1][15:0]});
    chk({response_code_word, monitor_result_a_high}, {RESP_OK, mv[3][15:0]});
    mv[1] = rnd();
    put();
    chk(monitor_result_a_low, mv[1][15:0]);
    m.mon(16'h1, 16'h3, 1'b0);
    v = mv[1];
    mv[1] = rnd();
    put();
    chk({monitor_active, monitor_result_a_low}, {1'b0, v[15:0]});
    m.mon(16'h0, 16'h9, 1'b1);
    chk(response_code_word, RESP_CODE_ERR);
    m.mon(16'h0, 16'h0, 1'b0);
    wr(REG_CFG, 32'h1);
    m.mon(16'h2, 16'h0, 1'b1);
    chk({monitor_result_a_low, monitor_result_a_high}, {mv[2][15:0], 16'hffff});
    chk({monitor_result_b_low, monitor_result_b_high}, {mv[0][15:0], mv[0][31:16]});
    m.mon(16'h2, 16'h0, 1'b0);
    v = rnd();
    d = v[15:0];
    m.instr(16'h8123, d, rd, dn);
    chk({dn, response_code_word}, {1'b1, RESP_OK});
    m.instr(16'h0123, 16'h0, rd, dn);
    chk({dn, rd}, {1'b1, d});
    wr(REG_REF_MASK, 32'h07fd);
    wr(REG_WR_LIMIT, 32'h00ff);
    for (int i = 0; i < 5; i++) begin
      m.instr(codes[i], 16'h0100, rd, dn);
      chk({dn, response_code_word}, {1'b1, resp[i]});
      chk(read_value_word, d);
    end
    wr(REG_REF_MASK, 32'h07ff);
    m.instr(16'h0123, 16'h0, rd, dn);
    chk(rd, d);
    m.setp(1'b0, 1'b0, 16'h7, 16'h0, 16'h0, pd, sd);
    chk(pd, 1'b0);
    m.setp(1'b1, 1'b0, 16'h7, 16'h0, 16'h0, pd, sd);
    chk({pd, setpoint_pos_table}, {1'b1, 16'h7});
    m.setp(1'b1, 1'b0, 16'h00ff, 16'h0, 16'h0, pd, sd);
    chk({pd, response_code_word}, {1'b0, RESP_CODE_ERR});
    wr(REG_SRC, 32'h1);
    v = rnd();
    m.setp(1'b1, 1'b1, v[15:0], v[31:16], 16'h5, pd, sd);
    chk({pd, sd, setpoint_speed_table}, {2'b11, 16'h5});
    chk(setpoint_position, v);
    wr(REG_SRC, 32'h2);
    m.setp(1'b1, 1'b1, 16'h0, 16'h0, d, pd, sd);
    chk({pd, sd, setpoint_speed_value, setpoint_accel_table}, {2'b11, d, ACCEL_TABLE_DIRECT});
    results();
  end
endmodule : servo_link_command_handshake_bench
